//--- hdl/gpio_pin_irq.sv
// gpio_pin_irq: twelve-pin interrupt detect, raw flags, enables and bit set/clear
// assumes pins synchronous to core_clk; single-cycle strobes from the bus master
//
// Contract
// - each pin's sense-select bit picks edge detection at 0 and level detection at 1.
// - with sense-select at 0 and both-edge at 1 every rising and falling transition triggers, else polarity rules.
// - polarity 0 triggers on rising edges or high level.
// - polarity 1 triggers on falling edges or low level.
// - a pin's enable bit at 1 lets it raise its interrupt, at 0 stops it.
// - a pin's interrupt goes out only while its raw flag and its enable are both set; the code registers pin_irq and irq, so they follow one cycle late.
// - the read-only raw flag shows 1 once the trigger occurred, regardless of enable.
// - writing 1 to the flag clear register clears that flag, 0 leaves it; the code keeps the flag set when a trigger hits in the same cycle.
// - writing 1 to the set register drives that output data bit to 1, 0 leaves it.
// - writing 1 to the clear-output register drives that output bit to 0, 0 leaves it.
// - configuration fields live in bits 11:0, reset to 0, bits 31:12 read zero.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module gpio_pin_irq #(
  parameter int unsigned PINS = gpio_irq_pkg::PIN_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [gpio_irq_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_irq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [gpio_irq_pkg::DATA_W-1:0] rdata,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_irq,
  output logic irq
);
  gpio_irq_pkg::bus_req_s req;
  gpio_irq_pkg::trig_cfg_s cfg;
  logic [PINS-1:0] pin_irq_enable;
  logic [PINS-1:0] raw_flags;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] flag_clear;
  logic [PINS-1:0] wfield;
  logic [gpio_irq_pkg::DATA_W-1:0] next_rdata;
  logic [PINS-1:0] next_pin_irq;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign wfield = req.wdata[PINS-1:0];

  // trigger detect per pin
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      pin_trigger u_trig (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(pin_in[g]),
        .sense_select(cfg.sense_select[g]),
        .both_edge_select(cfg.both_edge_select[g]),
        .polarity_select(cfg.polarity_select[g]),
        .hit(hit[g])
      );
    end
  endgenerate

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg.sense_select <= gpio_irq_pkg::FIELD_RESET;
      cfg.both_edge_select <= gpio_irq_pkg::FIELD_RESET;
      cfg.polarity_select <= gpio_irq_pkg::FIELD_RESET;
      pin_irq_enable <= gpio_irq_pkg::FIELD_RESET;
    end else if (req.wr) begin
      case (req.addr)
        gpio_irq_pkg::OFS_SENSE_SELECT: cfg.sense_select <= wfield;
        gpio_irq_pkg::OFS_BOTH_EDGE_SELECT: cfg.both_edge_select <= wfield;
        gpio_irq_pkg::OFS_POLARITY_SELECT: cfg.polarity_select <= wfield;
        gpio_irq_pkg::OFS_IRQ_ENABLE: pin_irq_enable <= wfield;
        default: ;
      endcase
    end
  end

  assign flag_clear = (req.wr && req.addr == gpio_irq_pkg::OFS_IRQ_FLAG_CLEAR) ?
    wfield : gpio_irq_pkg::FIELD_RESET;

  // raw flags: set wins over clear, level re-sets while held
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      raw_flags <= gpio_irq_pkg::FIELD_RESET;
    end else begin
      raw_flags <= (raw_flags & ~flag_clear) | hit;
    end
  end

  // output data with atomic set and clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_out <= gpio_irq_pkg::FIELD_RESET;
    end else if (req.wr) begin
      case (req.addr)
        gpio_irq_pkg::OFS_OUTPUT_BIT_SET: pin_out <= pin_out | wfield;
        gpio_irq_pkg::OFS_OUTPUT_BIT_CLEAR: pin_out <= pin_out & ~wfield;
        default: ;
      endcase
    end
  end

  // interrupt outputs from flops
  assign next_pin_irq = raw_flags & pin_irq_enable;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_irq <= gpio_irq_pkg::FIELD_RESET;
      irq <= 1'b0;
    end else begin
      pin_irq <= next_pin_irq;
      irq <= |next_pin_irq;
    end
  end

  // read mux, upper bits zero
  always_comb begin
    next_rdata = gpio_irq_pkg::READ_ZERO;
    case (req.addr)
      gpio_irq_pkg::OFS_SENSE_SELECT: next_rdata[PINS-1:0] = cfg.sense_select;
      gpio_irq_pkg::OFS_BOTH_EDGE_SELECT: next_rdata[PINS-1:0] = cfg.both_edge_select;
      gpio_irq_pkg::OFS_POLARITY_SELECT: next_rdata[PINS-1:0] = cfg.polarity_select;
      gpio_irq_pkg::OFS_IRQ_ENABLE: next_rdata[PINS-1:0] = pin_irq_enable;
      gpio_irq_pkg::OFS_IRQ_RAW_FLAGS: next_rdata[PINS-1:0] = raw_flags;
      gpio_irq_pkg::OFS_OUTPUT_DATA: next_rdata[PINS-1:0] = pin_out;
      default: next_rdata = gpio_irq_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata <= gpio_irq_pkg::READ_ZERO;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= gpio_irq_pkg::READ_ZERO;
    end
  end
endmodule

//--- common/gpio_irq_pkg.sv
// gpio_irq_pkg: register map, widths and carrier types for the pin interrupt block
// assumes a 32-bit plain register port and twelve pins per port
package gpio_irq_pkg;
  localparam int unsigned PIN_COUNT = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFS_SENSE_SELECT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BOTH_EDGE_SELECT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_POLARITY_SELECT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_RAW_FLAGS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_SET = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_CLEAR = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_DATA = 8'h30;

  localparam logic [PIN_COUNT-1:0] FIELD_RESET = 12'h000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sense_select;
    logic [PIN_COUNT-1:0] both_edge_select;
    logic [PIN_COUNT-1:0] polarity_select;
  } trig_cfg_s;
endpackage

//--- hdl/pin_trigger.sv
// pin_trigger: per-pin trigger detect for one pin
// assumes pin input already synchronous to core_clk
`timescale 1ns/1ns
module pin_trigger (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  input wire logic sense_select,
  input wire logic both_edge_select,
  input wire logic polarity_select,
  output logic hit
);
  logic pin_prev;
  logic rise;
  logic fall;

  // previous sample for edge compare
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  assign rise = pin_in & ~pin_prev;
  assign fall = ~pin_in & pin_prev;

  always_comb begin
    if (sense_select) begin
      hit = polarity_select ? ~pin_in : pin_in;
    end else if (both_edge_select) begin
      hit = rise | fall;
    end else begin
      hit = polarity_select ? fall : rise;
    end
  end
endmodule

//--- verification/gpio_pin_irq_assertions.sv
// checker: port-level timing of the pin interrupt block
// assumes it is bound to gpio_pin_irq
`timescale 1ns/1ns
module gpio_pin_irq_assertions #(
  parameter int unsigned PINS = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_irq,
  input wire logic irq
);
  logic [PINS-1:0] en;
  always_ff @(posedge core_clk) begin
    if (!rst_b) en <= '0;
    else if (wr && addr == 8'h18) en <= wdata[PINS-1:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  irq_or_a: assert property (irq == |pin_irq) else $error("irq not or of pin_irq");
  en_gate_a: assert property ((pin_irq & ~$past(en)) == '0) else $error("disabled irq");
  en_read_a: assert property (rd && addr == 8'h18 |=> rdata[PINS-1:0] == en)
    else $error("enable readback");
  set_bit_a: assert property (wr && addr == 8'h24 |=> pin_out ==
    ($past(pin_out) | $past(wdata[PINS-1:0]))) else $error("bit set");
  clr_bit_a: assert property (wr && addr == 8'h28 |=> pin_out ==
    ($past(pin_out) & ~$past(wdata[PINS-1:0]))) else $error("bit clear");
  out_hold_a: assert property (!(wr && (addr == 8'h24 || addr == 8'h28)) |=>
    $stable(pin_out)) else $error("output moved");
  rd_idle_a: assert property (!rd |=> rdata == '0) else $error("rdata not idle");
  rd_upper_a: assert property (rd |=> rdata[31:12] == '0) else $error("upper bits");
  wo_read_a: assert property (rd && (addr == 8'h20 || addr == 8'h24 || addr == 8'h28)
    |=> rdata == '0) else $error("write-only read");
endmodule

//--- verification/pin_drive_model.sv
// pin model: the outside world driving the port pins
// assumes levels change one clock after the bench commands them
`timescale 1ns/1ns
module pin_drive_model (
  input wire logic core_clk,
  input wire logic [11:0] level_cmd,
  output logic [11:0] pin_level
);
  initial pin_level = 12'h000;
  always @(posedge core_clk) pin_level <= level_cmd;
endmodule

//--- verification/gpio_pin_irq_tb.sv
// top bench: register traffic, pin stimulus and reference expectations
// assumes package, design, checker and pin model compiled first
`timescale 1ns/1ns
module gpio_pin_irq_tb;
  logic core_clk = 0, rst_b = 0, wr = 0, rd = 0, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [11:0] cmd = 12'h000, pin_in, pin_out, pin_irq, p0, p1, en, ex, mo = 12'h000;
  int miscompares = 0, compares = 0, seed = 94, m;
  gpio_pin_irq dut_u (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_irq(pin_irq), .irq(irq));
  pin_drive_model pins_u (.core_clk(core_clk), .level_cmd(cmd), .pin_level(pin_in));
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(string n, logic [11:0] s, logic [11:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic put(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic get(string n, logic [7:0] a, logic [11:0] e);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(n, rdata[11:0], e);
  endtask
  task automatic final_report;
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    for (m = 1; m <= 12; m++) get("reset", 8'(m * 4), 12'h000);
    for (m = 3; m <= 6; m++) begin
      r = $random(seed);
      put(8'(m * 4), r);
      get("cfg", 8'(m * 4), r[11:0]);
    end
    repeat (4) begin
      r = $random(seed);
      put(8'h24, r);
      mo = mo | r[11:0];
      chk("set", pin_out, mo);
      r = $random(seed);
      put(8'h28, r);
      mo = mo & ~r[11:0];
      get("out", 8'h30, mo);
    end
    for (m = 0; m < 5; m++) begin
      put(8'h0c, {32{m > 2}});
      put(8'h10, {32{m == 2}});
      put(8'h14, {32{m == 1 || m == 4}});
      r = $random(seed);
      en = r[11:0];
      put(8'h18, r);
      r = $random(seed);
      p0 = r[11:0];
      cmd <= p0;
      repeat (4) @(posedge core_clk);
      put(8'h20, 32'hfff);
      r = $random(seed);
      p1 = r[11:0];
      cmd <= p1;
      repeat (4) @(posedge core_clk);
      ex = m == 0 ? p1 & ~p0 : m == 1 ? p0 & ~p1 : m == 2 ? p0 ^ p1 : m == 3 ? p0 | p1 : ~(p0 & p1);
      get("raw", 8'h1c, ex);
      chk("pin_irq", pin_irq, ex & en);
      chk("irq", {11'h0, irq}, {11'h0, |(ex & en)});
      r = $random(seed);
      put(8'h20, r);
      ex = (ex & ~r[11:0]) | (m == 3 ? p1 : m == 4 ? ~p1 : 12'h000);
      get("raw_clr", 8'h1c, ex);
      chk("pin_irq", pin_irq, ex & en);
    end
    put(8'h0c, 32'h0);
    put(8'h14, 32'h0);
    cmd <= ~p1;
    put(8'h20, 32'hfff);
    get("set_wins", 8'h1c, ~p1);
    chk("pin_irq", pin_irq, ~p1 & en);
    final_report;
  end
endmodule
bind gpio_pin_irq gpio_pin_irq_assertions #(.PINS(PINS)) chk_u (.core_clk(core_clk),
  .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_irq(pin_irq), .irq(irq));
